// File: hw/sccss_card_clk.sv
`timescale 1ns/1ps
`include "sccss_defines.svh"

module sccss_card_clk #(
    parameter logic [`SCCSS_CC_W-1:0] HALF = `SCCSS_CC_W'(`SCCSS_CARD_CLK_HALF),
    parameter logic [`SCCSS_CC_W-1:0] HOLD = `SCCSS_CC_W'(`SCCSS_RST_HOLD_CLKS)
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ce,
    input  wire logic i_run,
    output logic      o_card_clk,
    output logic      o_hold_done
);

    logic [`SCCSS_CC_W-1:0] div_q;
    logic [`SCCSS_CC_W-1:0] edges_q;
    logic                   wrap;

    assign wrap = (div_q == HALF - 1'b1);

    // Clock starts low so the first card edge is a rising one
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q       <= '0;
            edges_q     <= '0;
            o_card_clk  <= 1'b0;
            o_hold_done <= 1'b0;
        end else if (i_ce) begin
            if (!i_run) begin
                div_q       <= '0;
                edges_q     <= '0;
                o_card_clk  <= 1'b0;
                o_hold_done <= 1'b0;
            end else if (wrap) begin
                div_q      <= '0;
                o_card_clk <= ~o_card_clk;
                if (!o_card_clk && !o_hold_done) begin
                    if (edges_q == HOLD - 1'b1) begin
                        o_hold_done <= 1'b1;
                    end else begin
                        edges_q <= edges_q + 1'b1;
                    end
                end
            end else begin
                div_q <= div_q + 1'b1;
            end
        end
    end

endmodule : sccss_card_clk

// File: hw/sccss_defines.svh
`ifndef SCCSS_DEFINES_SVH
`define SCCSS_DEFINES_SVH

// Reference clock rate
`define SCCSS_CLK_MHZ           40

// Least time in ns to whole clock cycles, rounded up
`define SCCSS_NS2CYC(ns)        ((((ns) * `SCCSS_CLK_MHZ) + 999) / 1000)

// Stabilization lockout after power-on, supply return or power-down exit
`define SCCSS_T_STAB_US         10000
`define SCCSS_STAB_CYC          (`SCCSS_T_STAB_US * `SCCSS_CLK_MHZ)

// Activation and deactivation step times
`define SCCSS_T_ACT_NS          50000
`define SCCSS_T1_NS             50000
`define SCCSS_T2_NS             20000
`define SCCSS_T3_NS             20000
`define SCCSS_T4_NS             20000
`define SCCSS_T_STEP_NS         5000
`define SCCSS_T_DISCH_NS        100000

// Card clock reset hold, in card clock cycles
`define SCCSS_RST_HOLD_CLKS     42000
// Reference cycles per card clock half period
`define SCCSS_CARD_CLK_HALF     2

// Counter widths
`define SCCSS_TMR_W             19
`define SCCSS_CC_W              16

`endif

// File: hw/sccss_pkg.sv
package sccss_pkg;

    typedef enum logic [11:0] {
        SCCSS_ST_PD        = 12'h001,
        SCCSS_ST_LOCK      = 12'h002,
        SCCSS_ST_IDLE      = 12'h004,
        SCCSS_ST_ACT_VCC   = 12'h008,
        SCCSS_ST_ACT_IO    = 12'h010,
        SCCSS_ST_ACT_CLK   = 12'h020,
        SCCSS_ST_ACT_RST   = 12'h040,
        SCCSS_ST_ACTIVE    = 12'h080,
        SCCSS_ST_DEACT_RST = 12'h100,
        SCCSS_ST_DEACT_CLK = 12'h200,
        SCCSS_ST_DEACT_IO  = 12'h400,
        SCCSS_ST_DEACT_VCC = 12'h800
    } sccss_state_t;

    typedef struct packed {
        logic host_supply_fault;
        logic card_supply_fault;
        logic over_current;
        logic over_temp;
    } sccss_fault_t;

    typedef struct packed {
        logic vcc_en;
        logic io_rx_en;
        logic clk;
        logic rst;
    } sccss_card_t;

endpackage : sccss_pkg

// File: hw/sccss_sequencer.sv
`timescale 1ns/1ps
`include "sccss_defines.svh"

// Functional notes
// - Either supply fault deactivates the card
// - Host supply fault reinitializes or deactivates
// - Power-down disables all analog functions
// - Card insertion raises alert during power-down
// - Alert rises after stabilization if card present
// - Requests during power-down or lockout ignored
// - Over-temperature deactivates and reports fault
// - Lockout after reset, supply return, power-down
// - Synchronous activation: supply and reception together, then signals
// - Host or fault deactivation; faults pull alert
// - Deactivate: reset, clock, reception, then supply
// - Asynchronous activation only with card present
// - Bad card supply after first interval aborts
// - Asynchronous: reception, clock, then reset follows
// - Card reset held for 42000 clocks
// - Reset high: reception on its fall, clock after
// - Asynchronous card supply fault deactivates
// - Activation needs a card present
// - Mode select low means asynchronous
// - Outside session alert shows presence only; the code shows presence in power-down and idle only
module sccss_sequencer
    import sccss_pkg::*;
#(
    parameter int unsigned              STAB_CYCLES = `SCCSS_STAB_CYC,
    parameter logic [`SCCSS_CC_W-1:0]   HOLD_CLKS   = `SCCSS_CC_W'(`SCCSS_RST_HOLD_CLKS),
    parameter logic [`SCCSS_CC_W-1:0]   CLK_HALF    = `SCCSS_CC_W'(`SCCSS_CARD_CLK_HALF)
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_arst_n,
    input  wire logic         i_clk_en,
    input  wire logic         i_activation_request_n,
    input  wire logic         i_power_down_in,
    input  wire logic         i_card_detect_in,
    input  wire logic         i_host_card_reset_in,
    input  wire logic         i_strobe_in,
    input  wire logic         i_clock_mode_select,
    input  wire sccss_fault_t i_faults,
    output sccss_card_t       o_card,
    output logic              o_alert_n,
    output logic              o_low_power_state,
    output logic              o_analog_en
);

    localparam int TW = `SCCSS_TMR_W;
    localparam logic [TW-1:0] C_ACT   = TW'(`SCCSS_NS2CYC(`SCCSS_T_ACT_NS));
    localparam logic [TW-1:0] C_T1    = TW'(`SCCSS_NS2CYC(`SCCSS_T1_NS));
    localparam logic [TW-1:0] C_T2    = TW'(`SCCSS_NS2CYC(`SCCSS_T2_NS));
    localparam logic [TW-1:0] C_T3    = TW'(`SCCSS_NS2CYC(`SCCSS_T3_NS));
    localparam logic [TW-1:0] C_T4    = TW'(`SCCSS_NS2CYC(`SCCSS_T4_NS));
    localparam logic [TW-1:0] C_STEP  = TW'(`SCCSS_NS2CYC(`SCCSS_T_STEP_NS));
    localparam logic [TW-1:0] C_DISCH = TW'(`SCCSS_NS2CYC(`SCCSS_T_DISCH_NS));
    localparam logic [TW-1:0] C_STAB  = TW'(STAB_CYCLES);
    localparam logic [TW-1:0] C_ONE   = TW'(1);

    // Activation or steady session, before any deactivation step
    function automatic logic in_session(input sccss_state_t s);
        in_session = (s == SCCSS_ST_ACT_VCC) || (s == SCCSS_ST_ACT_IO) || (s == SCCSS_ST_ACT_CLK) ||
                     (s == SCCSS_ST_ACT_RST) || (s == SCCSS_ST_ACTIVE);
    endfunction : in_session

    function automatic logic [TW-1:0] interval_of(input sccss_state_t s, input logic async_mode);
        case (s)
            SCCSS_ST_LOCK:      interval_of = C_STAB;
            SCCSS_ST_ACT_VCC:   interval_of = async_mode ? C_T1 : C_ACT;
            SCCSS_ST_ACT_IO:    interval_of = C_T2;
            SCCSS_ST_ACT_CLK:   interval_of = C_T3;
            SCCSS_ST_ACT_RST:   interval_of = async_mode ? C_T4 : C_T1;
            SCCSS_ST_DEACT_RST,
            SCCSS_ST_DEACT_CLK,
            SCCSS_ST_DEACT_IO:  interval_of = C_STEP;
            SCCSS_ST_DEACT_VCC: interval_of = C_DISCH;
            default:            interval_of = C_ONE;
        endcase
    endfunction : interval_of

    // Reset release through two flip-flops
    logic rst_meta_q;
    logic rst_n;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    sccss_state_t state_q;
    sccss_state_t state_d;
    logic         boot_q;
    logic         req_q;
    logic         host_card_reset_in_q;
    logic         rst_high_q;
    logic         fault_q;
    logic         fault_d;
    logic         tmr_exp;
    logic         tmr_load;
    logic         cc_clk;
    logic         cc_hold_done;
    sccss_card_t  card_d;
    logic         alert_n_d;

    wire async_mode    = !i_clock_mode_select;
    wire req_fell      = req_q && !i_activation_request_n;
    wire host_card_reset_in_fell    = host_card_reset_in_q && !i_host_card_reset_in;
    wire lock_hold     = boot_q || i_faults.host_supply_fault;
    wire st_active     = (state_q == SCCSS_ST_ACTIVE);
    wire vcc_checked   = async_mode ? (in_session(state_q) && state_q != SCCSS_ST_ACT_VCC) : st_active;
    wire card_fault    = i_faults.card_supply_fault;
    wire session_fault = i_faults.host_supply_fault || i_faults.over_current || i_faults.over_temp ||
                         !i_card_detect_in || (card_fault && vcc_checked);
    wire abort         = i_activation_request_n || session_fault;
    wire vcc_check_bad = (state_q == SCCSS_ST_ACT_VCC) && tmr_exp && async_mode && card_fault;
    wire fault_set     = (in_session(state_q) && session_fault) || vcc_check_bad;
    wire fault_clr     = (state_q == SCCSS_ST_IDLE) && i_activation_request_n;
    wire cc_run        = async_mode && (state_q == SCCSS_ST_ACT_RST || st_active ||
                                        state_q == SCCSS_ST_DEACT_RST);

    // Load the step timer on every state change; the lockout reloads while held
    assign tmr_load = (state_d != state_q) || ((state_q == SCCSS_ST_LOCK) && lock_hold);

    sccss_timer #(
        .W (TW)
    ) u_timer (
        .i_clk     (i_ref_clk),
        .i_rst_n   (rst_n),
        .i_ce      (i_clk_en),
        .i_load    (tmr_load),
        .i_value   (interval_of(state_d, async_mode)),
        .o_expired (tmr_exp)
    );

    sccss_card_clk #(
        .HALF (CLK_HALF),
        .HOLD (HOLD_CLKS)
    ) u_card_clk (
        .i_clk       (i_ref_clk),
        .i_rst_n     (rst_n),
        .i_ce        (i_clk_en),
        .i_run       (cc_run),
        .o_card_clk  (cc_clk),
        .o_hold_done (cc_hold_done)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            SCCSS_ST_PD: begin
                if (!i_power_down_in) begin
                    state_d = SCCSS_ST_LOCK;
                end
            end
            SCCSS_ST_LOCK: begin
                if (i_power_down_in) begin
                    state_d = SCCSS_ST_PD;
                end else if (tmr_exp && !lock_hold) begin
                    state_d = SCCSS_ST_IDLE;
                end
            end
            SCCSS_ST_IDLE: begin
                if (i_faults.host_supply_fault) begin
                    state_d = SCCSS_ST_LOCK;
                end else if (i_power_down_in) begin
                    state_d = SCCSS_ST_PD;
                end else if (req_fell && i_card_detect_in) begin
                    state_d = SCCSS_ST_ACT_VCC;
                end
            end
            SCCSS_ST_ACT_VCC: begin
                if (abort) begin
                    state_d = SCCSS_ST_DEACT_RST;
                end else if (vcc_check_bad) begin
                    state_d = SCCSS_ST_DEACT_VCC;
                end else if (tmr_exp) begin
                    state_d = async_mode ? SCCSS_ST_ACT_IO : SCCSS_ST_ACT_RST;
                end
            end
            SCCSS_ST_ACT_IO: begin
                if (abort) begin
                    state_d = SCCSS_ST_DEACT_RST;
                end else if (rst_high_q ? host_card_reset_in_fell : tmr_exp) begin
                    state_d = SCCSS_ST_ACT_CLK;
                end
            end
            SCCSS_ST_ACT_CLK: begin
                if (abort) begin
                    state_d = SCCSS_ST_DEACT_RST;
                end else if (tmr_exp) begin
                    state_d = SCCSS_ST_ACT_RST;
                end
            end
            SCCSS_ST_ACT_RST: begin
                if (abort) begin
                    state_d = SCCSS_ST_DEACT_RST;
                end else if (tmr_exp) begin
                    state_d = SCCSS_ST_ACTIVE;
                end
            end
            SCCSS_ST_ACTIVE: begin
                // Power-down is not honoured here; the host keeps it low in a session
                if (abort) begin
                    state_d = SCCSS_ST_DEACT_RST;
                end
            end
            SCCSS_ST_DEACT_RST: begin
                if (tmr_exp) begin
                    state_d = SCCSS_ST_DEACT_CLK;
                end
            end
            SCCSS_ST_DEACT_CLK: begin
                if (tmr_exp) begin
                    state_d = SCCSS_ST_DEACT_IO;
                end
            end
            SCCSS_ST_DEACT_IO: begin
                if (tmr_exp) begin
                    state_d = SCCSS_ST_DEACT_VCC;
                end
            end
            SCCSS_ST_DEACT_VCC: begin
                if (tmr_exp) begin
                    state_d = SCCSS_ST_IDLE;
                end
            end
            default: begin
                state_d = SCCSS_ST_LOCK;
            end
        endcase
    end

    // Set wins over clear so a fault in the clearing cycle is kept
    assign fault_d = fault_set ? 1'b1 : (fault_clr ? 1'b0 : fault_q);

    // Low during lockout so the rise marks recovery; presence only in power-down and idle
    assign alert_n_d = (state_q == SCCSS_ST_LOCK) ? 1'b0 :
                       fault_d                     ? 1'b0 :
                       ((state_q == SCCSS_ST_PD) || (state_q == SCCSS_ST_IDLE)) ? i_card_detect_in :
                       1'b1;

    assign card_d.vcc_en   = ((state_q == SCCSS_ST_ACT_VCC) && async_mode) ||
                             (state_q == SCCSS_ST_ACT_IO) || (state_q == SCCSS_ST_ACT_CLK) ||
                             (state_q == SCCSS_ST_ACT_RST) || st_active ||
                             (state_q == SCCSS_ST_DEACT_RST) || (state_q == SCCSS_ST_DEACT_CLK) ||
                             (state_q == SCCSS_ST_DEACT_IO);
    assign card_d.io_rx_en = (state_q == SCCSS_ST_ACT_CLK) || (state_q == SCCSS_ST_ACT_RST) || st_active ||
                             (state_q == SCCSS_ST_DEACT_RST) || (state_q == SCCSS_ST_DEACT_CLK);
    assign card_d.clk      = async_mode ? cc_clk :
                             (i_strobe_in && (st_active || state_q == SCCSS_ST_DEACT_RST));
    assign card_d.rst      = st_active && i_host_card_reset_in && (!async_mode || cc_hold_done);

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= SCCSS_ST_LOCK;
            boot_q     <= 1'b1;
            req_q      <= 1'b1;
            host_card_reset_in_q    <= 1'b0;
            rst_high_q <= 1'b0;
            fault_q    <= 1'b0;
        end else if (i_clk_en) begin
            state_q <= state_d;
            boot_q  <= 1'b0;
            req_q   <= i_activation_request_n;
            host_card_reset_in_q <= i_host_card_reset_in;
            fault_q <= fault_d;
            if (state_q == SCCSS_ST_IDLE) begin
                rst_high_q <= i_host_card_reset_in;
            end
        end
    end

    // Outputs straight from flip-flops
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_card            <= '0;
            o_alert_n         <= 1'b0;
            o_low_power_state <= 1'b0;
            o_analog_en       <= 1'b0;
        end else if (i_clk_en) begin
            o_card            <= card_d;
            o_alert_n         <= alert_n_d;
            o_low_power_state <= (state_q == SCCSS_ST_PD);
            o_analog_en       <= (state_q != SCCSS_ST_PD);
        end
    end

    property p_pd_analog_off;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && state_q == SCCSS_ST_PD) |=> (o_low_power_state && !o_analog_en && !o_card.vcc_en);
    endproperty
    a_pd_analog_off: assert property (p_pd_analog_off) else $error("analog left on in power-down");

    property p_pd_presence;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && state_q == SCCSS_ST_PD) |=> (o_alert_n == $past(i_card_detect_in));
    endproperty
    a_pd_presence: assert property (p_pd_presence) else $error("alert ignores card in power-down");

    property p_lock_blocks;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && (state_q == SCCSS_ST_LOCK || state_q == SCCSS_ST_PD)) |=> (state_q != SCCSS_ST_ACT_VCC);
    endproperty
    a_lock_blocks: assert property (p_lock_blocks) else $error("activation taken during lockout");

    property p_idle_presence;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && state_q == SCCSS_ST_IDLE && i_activation_request_n) |=> (o_alert_n == $past(i_card_detect_in));
    endproperty
    a_idle_presence: assert property (p_idle_presence) else $error("idle alert not card presence");

    property p_fault_alert;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && in_session(state_q) && session_fault) |=> (!o_alert_n && state_q == SCCSS_ST_DEACT_RST);
    endproperty
    a_fault_alert: assert property (p_fault_alert) else $error("session fault not reported");

    property p_deact_order;
        @(posedge i_ref_clk) disable iff (!rst_n)
        $fell(o_card.vcc_en) |-> (!o_card.io_rx_en && !o_card.clk && !o_card.rst && !$past(o_card.io_rx_en));
    endproperty
    a_deact_order: assert property (p_deact_order) else $error("supply dropped before signals");

    property p_rst_hold;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (o_card.rst && !i_clock_mode_select) |-> $past(cc_hold_done);
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("card reset before clock hold");

    property p_clk_after_rx;
        @(posedge i_ref_clk) disable iff (!rst_n)
        ($rose(o_card.clk) && !i_clock_mode_select) |-> o_card.io_rx_en;
    endproperty
    a_clk_after_rx: assert property (p_clk_after_rx) else $error("clock before reception");

    property p_vcc_check;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && vcc_check_bad && !abort) |=> (state_q == SCCSS_ST_DEACT_VCC && !o_alert_n);
    endproperty
    a_vcc_check: assert property (p_vcc_check) else $error("bad card supply not aborted");

    property p_no_card_no_act;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_clk_en && state_q == SCCSS_ST_IDLE && !i_card_detect_in) |=> (state_q != SCCSS_ST_ACT_VCC);
    endproperty
    a_no_card_no_act: assert property (p_no_card_no_act) else $error("activation without card");

endmodule : sccss_sequencer

// File: hw/sccss_timer.sv
`timescale 1ns/1ps
`include "sccss_defines.svh"

module sccss_timer #(
    parameter int unsigned W = `SCCSS_TMR_W
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_ce,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    output logic              o_expired
);

    logic [W-1:0] cnt_q;

    // Expires i_value cycles after the load
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= '0;
        end else if (i_ce) begin
            if (i_load) begin
                cnt_q <= i_value;
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    assign o_expired = (cnt_q == '0);

endmodule : sccss_timer

// File: sim/sccss_host_model.sv
`timescale 1ns/1ps
module sccss_host_model (
    input  wire logic i_clk,
    output logic      o_req_n,
    output logic      o_pd,
    output logic      o_rst,
    output logic      o_strobe
);
    initial begin
        o_req_n  = 1'h1;
        o_pd     = 1'h0;
        o_rst    = 1'h0;
        o_strobe = 1'h0;
    end
    // Power-down is only raised with the request high, so a session is never cut
    task automatic set(input logic req, input logic pd, input logic rst, input logic stb);
        @(posedge i_clk);
        o_req_n  <= req;
        o_pd     <= pd & req;
        o_rst    <= rst;
        o_strobe <= stb;
    endtask : set
endmodule : sccss_host_model

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import sccss_pkg::*;
    logic         clk = 1'h0;
    logic         arst_n = 1'h0;
    logic         det = 1'h1;
    logic         mode = 1'h0;
    logic         ce = 1'h1;
    sccss_fault_t flt = '0;
    sccss_card_t  card;
    logic         req_n, pd, hrst, stb, alert_n, lp, an;
    int           fail_count = 0;
    int           check_count = 0;
    int           cyc = 0;
    always #12.5 clk = ~clk;
    sccss_host_model host (.i_clk(clk), .o_req_n(req_n), .o_pd(pd), .o_rst(hrst), .o_strobe(stb));
    // Hold longer than the last activation step so the card clock count, not the timer, gates reset
    sccss_sequencer #(.STAB_CYCLES(50), .HOLD_CLKS(16'h012C)) dut (
        .i_ref_clk(clk), .i_arst_n(arst_n), .i_clk_en(ce), .i_activation_request_n(req_n),
        .i_power_down_in(pd), .i_card_detect_in(det), .i_host_card_reset_in(hrst),
        .i_strobe_in(stb), .i_clock_mode_select(mode), .i_faults(flt), .o_card(card),
        .o_alert_n(alert_n), .o_low_power_state(lp), .o_analog_en(an));
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Bounded wait on card lines, sampled at the falling edge to stay clear of updates
    task automatic wait_card(input logic [3:0] m, input logic [3:0] v);
        int n;
        n = 0;
        while ((card & m) !== v && n < 6000) begin
            @(negedge clk);
            n++;
        end
        chk("card", v, card & m);
    endtask : wait_card
    always @(posedge clk) begin
        cyc++;
        if (cyc == 45000) begin
            fail_count++;
            conclude();
        end
    end
    logic [3:0] dexp [4] = '{4'hE, 4'hC, 4'h8, 4'h0};
    int         dly  [4] = '{100, 200, 200, 200};
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'h1;
        host.set(1'h1, 1'h0, 1'h0, 1'h0);
        // Asynchronous mode here so a wrongly taken request would show supply within two cycles
        host.set(1'h0, 1'h0, 1'h0, 1'h0);
        repeat (5) @(negedge clk);
        chk("vcc_lock", 4'h0, 4'(card.vcc_en));
        chk("alert_lock", 4'h0, 4'(alert_n));
        repeat (60) @(negedge clk);
        chk("alert_stab", 4'h1, 4'(alert_n));
        chk("vcc_after_lock", 4'h0, card);
        $display("test lockout done");
        @(posedge clk) mode <= 1'h1;
        host.set(1'h1, 1'h0, 1'h1, 1'h1);
        host.set(1'h0, 1'h0, 1'h1, 1'h1);
        wait_card(4'h8, 4'h8);
        chk("sync_early", 4'hC, card);
        wait_card(4'h3, 4'h3);
        host.set(1'h0, 1'h0, 1'h0, 1'h0);
        repeat (3) @(negedge clk);
        chk("sync_follow", 4'hC, card);
        host.set(1'h1, 1'h0, 1'h0, 1'h1);
        for (int k = 0; k < 4; k++) begin
            repeat (dly[k]) @(negedge clk);
            chk("deact", dexp[k], card);
        end
        chk("alert_host", 4'h1, 4'(alert_n));
        repeat (4100) @(posedge clk);
        $display("test sync done");
        mode <= 1'h0;
        host.set(1'h0, 1'h0, 1'h0, 1'h0);
        wait_card(4'h4, 4'h4);
        chk("async_io", 4'hC, card);
        wait_card(4'h2, 4'h2);
        host.set(1'h0, 1'h0, 1'h1, 1'h0);
        repeat (1000) @(negedge clk);
        chk("rst_hold", 4'h0, 4'(card.rst));
        wait_card(4'h1, 4'h1);
        @(posedge clk) flt.over_temp <= 1'h1;
        repeat (3) @(negedge clk);
        chk("alert_fault", 4'h0, 4'(alert_n));
        wait_card(4'hF, 4'h0);
        @(posedge clk) flt <= '0;
        host.set(1'h1, 1'h0, 1'h0, 1'h0);
        repeat (4300) @(negedge clk);
        chk("alert_idle", 4'h1, 4'(alert_n));
        $display("test async done");
        // Past both first timed steps, so reception can only wait on the reset fall
        host.set(1'h0, 1'h0, 1'h1, 1'h0);
        repeat (3000) @(negedge clk);
        chk("rx_wait", 4'h8, card);
        host.set(1'h0, 1'h0, 1'h0, 1'h0);
        repeat (3) @(negedge clk);
        chk("rx_on_fall", 4'hC, card);
        @(posedge clk) flt.card_supply_fault <= 1'h1;
        repeat (3) @(negedge clk);
        chk("alert_vcc_fault", 4'h0, 4'(alert_n));
        wait_card(4'hF, 4'h0);
        host.set(1'h1, 1'h0, 1'h0, 1'h0);
        repeat (4300) @(negedge clk);
        chk("idle_vcc_fault", 4'h1, 4'(alert_n));
        $display("test reset high done");
        host.set(1'h0, 1'h0, 1'h0, 1'h0);
        repeat (100) @(negedge clk);
        chk("vcc_on", 4'h8, card);
        repeat (2000) @(negedge clk);
        chk("vcc_bad", 4'h0, card);
        chk("alert_vcc_bad", 4'h0, 4'(alert_n));
        @(posedge clk) flt <= '0;
        host.set(1'h1, 1'h0, 1'h0, 1'h0);
        repeat (4100) @(negedge clk);
        chk("alert_recover", 4'h1, 4'(alert_n));
        $display("test supply check done");
        @(posedge clk) flt.over_current <= 1'h1;
        repeat (20) @(negedge clk);
        chk("idle_fault", 4'h1, {card.vcc_en, 2'h0, alert_n});
        @(posedge clk) flt <= '0;
        @(posedge clk) flt.host_supply_fault <= 1'h1;
        repeat (5) @(negedge clk);
        chk("host_supply_lock", 4'h0, 4'(alert_n));
        @(posedge clk) flt <= '0;
        repeat (60) @(negedge clk);
        chk("host_supply_back", 4'h1, 4'(alert_n));
        @(posedge clk) det <= 1'h0;
        host.set(1'h1, 1'h1, 1'h0, 1'h0);
        repeat (5) @(negedge clk);
        chk("pd", 4'h4, {1'h0, lp, an, alert_n});
        @(posedge clk) det <= 1'h1;
        repeat (5) @(negedge clk);
        chk("pd_insert", 4'h1, 4'(alert_n));
        host.set(1'h1, 1'h0, 1'h0, 1'h0);
        repeat (5) @(negedge clk);
        chk("pd_exit", 4'h0, 4'(alert_n));
        // Frozen clock enable must stretch the lockout past its normal end
        @(posedge clk) ce <= 1'h0;
        repeat (60) @(negedge clk);
        chk("ce_freeze", 4'h0, 4'(alert_n));
        @(posedge clk) ce <= 1'h1;
        repeat (60) @(negedge clk);
        chk("pd_stab", 4'h1, 4'(alert_n));
        $display("test power down done");
        conclude();
    end
endmodule : tb_top
